/* File: pkg/aicd_pkg.sv */
// register map, field layout and constants of the converter control block
package aicd_pkg;
  localparam int          NUM_EXC          = 7;
  // exception bit positions
  localparam int          EXC_RDY          = 0;
  localparam int          EXC_OFS_OVF      = 1;
  localparam int          EXC_GAIN_OVF     = 2;
  localparam int          EXC_NEG_SAT      = 3;
  localparam int          EXC_POS_SAT      = 4;
  localparam int          EXC_OVERRUN      = 5;
  localparam int          EXC_UNDERRUN     = 6;
  // byte offsets
  localparam logic [7:0]  OFS_MASKED_STAT  = 8'h00;
  localparam logic [7:0]  OFS_MASK         = 8'h04;
  localparam logic [7:0]  OFS_RAW_STAT     = 8'h08;
  localparam logic [7:0]  OFS_CLEAR        = 8'h0C;
  localparam logic [7:0]  OFS_CMD          = 8'h10;
  localparam logic [7:0]  OFS_GENERAL      = 8'h14;
  localparam logic [7:0]  OFS_CONFIG       = 8'h18;
  localparam logic [7:0]  OFS_OFFSET_CAL   = 8'h1C;
  localparam logic [7:0]  OFS_GAIN_CAL     = 8'h20;
  localparam logic [7:0]  OFS_DMA          = 8'h24;
  localparam logic [7:0]  OFS_ANA          = 8'h28;
  localparam logic [7:0]  OFS_RESULT       = 8'h2C;
  // fields
  localparam int          CMD_GO           = 0;
  localparam int          GEN_GLOBAL_EN    = 0;
  localparam int          GEN_CAL_EN       = 1;
  localparam int          CFG_CAL_RST      = 0;
  localparam int          CFG_CAL_SEL      = 1;
  localparam int          CFG_TRIG_EN      = 2;
  localparam int          DMA_EN_BIT       = 0;
  localparam int          DMA_THL_LSB      = 8;
  localparam int          ANA_AMUX_LSB     = 0;
  localparam int          ANA_POL_BIT      = 4;
  localparam int          ANA_OSR_LSB      = 8;
  // reset values
  localparam logic [6:0]  MASK_RST         = 7'h7F;
  localparam logic [15:0] ZERO16           = 16'h0000;
  // gain references, lowest oversampling code and battery input select
  localparam logic [15:0] FS_SELF          = 16'h7FFF;
  localparam logic [15:0] FS_SYSTEM        = 16'h7AE1;
  localparam logic [1:0]  OSR_LOWEST       = 2'b00;
  localparam logic [3:0]  AMUX_BATTERY     = 4'b1000;
endpackage

/* File: design/aicd_top.sv */
// converter control: interrupts, calibration, dma request, trigger start
// How it works
// - one active-high level interrupt while any unmasked exception pends
// - seven exceptions recorded: ready, two cal overflows, two saturations, overrun, underrun
// - masked status reads one per pending unmasked exception
// - mask register read/write; a one blocks that exception from the interrupt
// - all mask bits reset to one
// - raw status shows every pending exception regardless of mask
// - clear register write-only; writing one clears, zero does nothing
// - calibration end clears cal enable; each calibration sample stores offset or gain
// - cal-data reset forces stored offset and gain to zero
// - cal source select one applies user coefficients
// - self offset uses the ground-to-ground sample
// - self gain is one minus sample over 0x7FFF
// - system gain with external reference uses 0x7AE1
// - dma request raised when fifo count reaches a nonzero threshold with dma enabled
// - dma request clears after result read and acknowledge
// - timer event starts conversion when powered and trigger enabled
// - lowest oversampling result is twelve-bit sign-extended to sixteen
// - result valid when ready flag set, two's complement
module aicd_top #(
  parameter int FIFO_DEPTH_W = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        core_sample_valid,
  input  wire logic [15:0] core_sample,
  input  wire logic        core_cal_done,
  input  wire logic        core_overrun,
  input  wire logic        core_underrun,
  input  wire logic [FIFO_DEPTH_W-1:0] core_fifo_count,
  output logic             core_start,
  output logic             core_cal_mode,
  output logic             core_system_gain,
  output logic [3:0]       analog_input_select,
  output logic             input_polarity_mode,
  output logic [1:0]       oversampling_setting,
  output logic             dma_req,
  input  wire logic        dma_ack,
  input  wire logic        trigger_timer
);
  ////////////////////////////////////////////////////////////////////////////
  logic [6:0]  raw_r;
  logic [6:0]  mask_r;
  logic        go_r;
  logic        global_en_r;
  logic        cal_en_r;
  logic        cal_sel_r;
  logic        trig_en_r;
  logic        sys_gain_r;
  logic [15:0] offset_cal_r;
  logic [15:0] gain_cal_r;
  logic [15:0] user_offset_correction;
  logic [15:0] user_gain_correction;
  logic        dma_en_r;
  logic [FIFO_DEPTH_W-1:0] fifo_request_threshold;
  logic [3:0]  amux_r;
  logic        pol_r;
  logic [1:0]  osr_r;
  logic [15:0] result_r;
  logic [31:0] rdata_nxt;
  logic        waitreq_r;
  logic        irq_r;
  logic        trig_s1_r;
  logic        trig_s2_r;
  logic        trig_s3_r;
  logic        start_r;
  logic        dma_r;
  logic        dma_read_seen_r;
  logic        cal_phase_r;
  logic [6:0]  event_set;
  logic [16:0] corr_sum;
  logic [15:0] corrected;
  logic        neg_sat;
  logic        pos_sat;
  logic [15:0] ofs_apply;
  logic [15:0] gain_apply;
  logic [31:0] gain_prod;
  logic [16:0] gain_calc;
  logic        wr_acc;
  logic        rd_acc;
  logic        trig_evt;
  logic        result_read;

  // one wait cycle per access so read data come from a flop
  assign wr_acc      = avs_write && !avs_waitrequest;
  assign rd_acc      = avs_read && !avs_waitrequest;
  assign result_read = rd_acc && (avs_address == aicd_pkg::OFS_RESULT);

  function automatic logic [15:0] sext12(input logic [15:0] s);
    sext12 = {{4{s[11]}}, s[11:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // correction datapath
  assign ofs_apply  = cal_sel_r ? user_offset_correction : offset_cal_r;
  assign gain_apply = cal_sel_r ? user_gain_correction : gain_cal_r;
  assign corr_sum   = {core_sample[15], core_sample} - {ofs_apply[15], ofs_apply};
  // gain held as signed q15 deviation from unity
  assign gain_prod  = $signed({{16{corr_sum[15]}}, corr_sum[15:0]}) * $signed({{16{gain_apply[15]}}, gain_apply});
  assign gain_calc  = {corr_sum[16], corr_sum[15:0]} + {gain_prod[31], gain_prod[30:15]};
  assign neg_sat    = gain_calc[16] && !gain_calc[15];
  assign pos_sat    = !gain_calc[16] && gain_calc[15];
  always_comb begin
    if (neg_sat) begin
      corrected = 16'h8000;
    end else if (pos_sat) begin
      corrected = 16'h7FFF;
    end else begin
      corrected = gain_calc[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exception events, ordered to match every irq register
  always_comb begin
    event_set = 7'h00;
    event_set[aicd_pkg::EXC_RDY]      = core_sample_valid && !cal_phase_r;
    event_set[aicd_pkg::EXC_OFS_OVF]  = core_sample_valid && cal_phase_r && !sys_gain_r
                                        && (corr_sum[16] != corr_sum[15]);
    event_set[aicd_pkg::EXC_GAIN_OVF] = core_sample_valid && cal_phase_r && sys_gain_r
                                        && (core_sample[15]);
    event_set[aicd_pkg::EXC_NEG_SAT]  = core_sample_valid && !cal_phase_r && neg_sat;
    event_set[aicd_pkg::EXC_POS_SAT]  = core_sample_valid && !cal_phase_r && pos_sat;
    event_set[aicd_pkg::EXC_OVERRUN]  = core_overrun;
    event_set[aicd_pkg::EXC_UNDERRUN] = core_underrun;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      raw_r <= 7'h00;
    end else begin
      // set wins over clear
      if (wr_acc && avs_address == aicd_pkg::OFS_CLEAR && avs_byteenable[0]) begin
        raw_r <= (raw_r & ~avs_writedata[6:0]) | event_set;
      end else begin
        raw_r <= raw_r | event_set;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(raw_r & ~mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r                 <= aicd_pkg::MASK_RST;
      go_r                   <= 1'b0;
      global_en_r            <= 1'b0;
      cal_sel_r              <= 1'b0;
      trig_en_r              <= 1'b0;
      sys_gain_r             <= 1'b0;
      user_offset_correction <= aicd_pkg::ZERO16;
      user_gain_correction   <= aicd_pkg::ZERO16;
      dma_en_r               <= 1'b0;
      fifo_request_threshold <= '0;
      amux_r                 <= 4'h0;
      pol_r                  <= 1'b0;
      osr_r                  <= aicd_pkg::OSR_LOWEST;
    end else if (wr_acc && avs_byteenable[0]) begin
      case (avs_address)
        aicd_pkg::OFS_MASK: mask_r <= avs_writedata[6:0];
        aicd_pkg::OFS_CMD: go_r <= avs_writedata[aicd_pkg::CMD_GO];
        aicd_pkg::OFS_GENERAL: global_en_r <= avs_writedata[aicd_pkg::GEN_GLOBAL_EN];
        aicd_pkg::OFS_CONFIG: begin
          cal_sel_r  <= avs_writedata[aicd_pkg::CFG_CAL_SEL];
          trig_en_r  <= avs_writedata[aicd_pkg::CFG_TRIG_EN];
          sys_gain_r <= avs_writedata[3];
        end
        aicd_pkg::OFS_OFFSET_CAL: user_offset_correction <= avs_writedata[31:16];
        aicd_pkg::OFS_GAIN_CAL: user_gain_correction <= avs_writedata[31:16];
        aicd_pkg::OFS_DMA: begin
          dma_en_r               <= avs_writedata[aicd_pkg::DMA_EN_BIT];
          fifo_request_threshold <= avs_writedata[aicd_pkg::DMA_THL_LSB +: FIFO_DEPTH_W];
        end
        aicd_pkg::OFS_ANA: begin
          amux_r <= avs_writedata[aicd_pkg::ANA_AMUX_LSB +: 4];
          pol_r  <= avs_writedata[aicd_pkg::ANA_POL_BIT];
        end
        default: ;
      endcase
    end else if (wr_acc && avs_byteenable[1] && avs_address == aicd_pkg::OFS_ANA) begin
      osr_r <= avs_writedata[aicd_pkg::ANA_OSR_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration: go rising with cal enable set runs a calibration conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_en_r    <= 1'b0;
      cal_phase_r <= 1'b0;
    end else begin
      if (wr_acc && avs_address == aicd_pkg::OFS_GENERAL && avs_byteenable[0]) begin
        cal_en_r <= avs_writedata[aicd_pkg::GEN_CAL_EN];
      end
      if (wr_acc && avs_address == aicd_pkg::OFS_CMD && avs_writedata[aicd_pkg::CMD_GO]
          && !go_r && cal_en_r) begin
        cal_phase_r <= 1'b1;
      end
      if (cal_phase_r && core_cal_done) begin
        cal_en_r    <= 1'b0;
        cal_phase_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      offset_cal_r <= aicd_pkg::ZERO16;
      gain_cal_r   <= aicd_pkg::ZERO16;
    end else if (wr_acc && avs_address == aicd_pkg::OFS_CONFIG && avs_byteenable[0]
                 && avs_writedata[aicd_pkg::CFG_CAL_RST]) begin
      offset_cal_r <= aicd_pkg::ZERO16;
      gain_cal_r   <= aicd_pkg::ZERO16;
    end else if (cal_phase_r && core_sample_valid) begin
      if (!sys_gain_r && amux_r != 4'b1001) begin
        offset_cal_r <= core_sample;
      end else if (sys_gain_r) begin
        gain_cal_r <= aicd_pkg::FS_SYSTEM - core_sample;
      end else begin
        gain_cal_r <= aicd_pkg::FS_SELF - core_sample;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result register
  always_ff @(posedge clk) begin
    if (rst) begin
      result_r <= aicd_pkg::ZERO16;
    end else if (core_sample_valid && !cal_phase_r) begin
      result_r <= (osr_r == aicd_pkg::OSR_LOWEST) ? sext12(corrected) : corrected;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger timer: synchronised, rising edge starts a conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else begin
      trig_s1_r <= trigger_timer;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end
  assign trig_evt = trig_s2_r && !trig_s3_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      start_r <= 1'b0;
    end else begin
      start_r <= global_en_r && (go_r || (trig_en_r && trig_evt));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma request: held until result read and acknowledge seen
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_r           <= 1'b0;
      dma_read_seen_r <= 1'b0;
    end else if (!dma_r) begin
      dma_read_seen_r <= 1'b0;
      dma_r <= dma_en_r && (core_fifo_count >= fifo_request_threshold)
               && (fifo_request_threshold != '0);
    end else begin
      if (result_read) begin
        dma_read_seen_r <= 1'b1;
      end
      if ((dma_read_seen_r || result_read) && dma_ack) begin
        dma_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave, fixed one wait state
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address)
      aicd_pkg::OFS_MASKED_STAT: rdata_nxt[6:0] = raw_r & ~mask_r;
      aicd_pkg::OFS_MASK:        rdata_nxt[6:0] = mask_r;
      aicd_pkg::OFS_RAW_STAT:    rdata_nxt[6:0] = raw_r;
      aicd_pkg::OFS_CMD:         rdata_nxt[0] = go_r;
      aicd_pkg::OFS_GENERAL:     rdata_nxt[1:0] = {cal_en_r, global_en_r};
      aicd_pkg::OFS_CONFIG:      rdata_nxt[3:1] = {sys_gain_r, trig_en_r, cal_sel_r};
      aicd_pkg::OFS_OFFSET_CAL:  rdata_nxt = {user_offset_correction, offset_cal_r};
      aicd_pkg::OFS_GAIN_CAL:    rdata_nxt = {user_gain_correction, gain_cal_r};
      aicd_pkg::OFS_DMA:         rdata_nxt[aicd_pkg::DMA_THL_LSB +: FIFO_DEPTH_W] = fifo_request_threshold;
      aicd_pkg::OFS_ANA:         rdata_nxt[9:0] = {osr_r, 3'b000, pol_r, amux_r};
      aicd_pkg::OFS_RESULT:      rdata_nxt[15:0] = result_r;
      default:                   rdata_nxt = 32'h0000_0000;
    endcase
    if (avs_address == aicd_pkg::OFS_DMA) begin
      rdata_nxt[aicd_pkg::DMA_EN_BIT] = dma_en_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      waitreq_r    <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      waitreq_r    <= !((avs_read || avs_write) && waitreq_r);
      avs_readdata <= rdata_nxt;
    end
  end
  assign avs_waitrequest = waitreq_r;

  ////////////////////////////////////////////////////////////////////////////
  assign irq                  = irq_r;
  assign core_start           = start_r;
  assign core_cal_mode        = cal_phase_r;
  assign core_system_gain     = sys_gain_r;
  assign analog_input_select  = amux_r;
  assign input_polarity_mode  = pol_r;
  assign oversampling_setting = osr_r;
  assign dma_req              = dma_r;

  ////////////////////////////////////////////////////////////////////////////
  a_irq_follows: assert property (@(posedge clk) disable iff (rst)
    ##1 irq == |($past(raw_r) & ~$past(mask_r))) else $error("irq mismatch");
  a_masked_never: assert property (@(posedge clk) disable iff (rst)
    (mask_r == 7'h7F) |=> !irq) else $error("masked irq seen");
  a_raw_sticky: assert property (@(posedge clk) disable iff (rst)
    (raw_r[0] && !(wr_acc && avs_address == aicd_pkg::OFS_CLEAR)) |=> raw_r[0])
    else $error("raw bit lost");
  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    event_set[aicd_pkg::EXC_OVERRUN] |=> raw_r[aicd_pkg::EXC_OVERRUN]) else $error("event lost");
  a_clear_works: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && avs_address == aicd_pkg::OFS_CLEAR && avs_byteenable[0] && avs_writedata[6]
     && !event_set[6]) |=> !raw_r[6]) else $error("clear failed");
  a_cal_rst: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && avs_address == aicd_pkg::OFS_CONFIG && avs_byteenable[0] && avs_writedata[0])
    |=> (offset_cal_r == 16'h0000 && gain_cal_r == 16'h0000)) else $error("cal reset failed");
  a_cal_done_clr: assert property (@(posedge clk) disable iff (rst)
    (cal_phase_r && core_cal_done) |=> !cal_en_r) else $error("cal enable stuck");
  a_trig_start: assert property (@(posedge clk) disable iff (rst)
    (trig_evt && global_en_r && trig_en_r) |=> core_start) else $error("trigger missed");
  a_dma_hold: assert property (@(posedge clk) disable iff (rst)
    (dma_r && !dma_ack) |=> dma_r) else $error("dma dropped early");
endmodule

/* File: sim/aicd_partner.sv */
// far-side model: converter core, dma controller and trigger timer
module aicd_partner (
  input  wire logic clk,
  output logic      core_sample_valid,
  output logic [15:0] core_sample,
  output logic      core_cal_done,
  output logic      core_overrun,
  output logic      core_underrun,
  output logic [3:0] core_fifo_count,
  output logic      dma_ack,
  output logic      trigger_timer
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    core_sample_valid = 1'b0;
    core_sample = 16'h0000;
    core_cal_done = 1'b0;
    core_overrun = 1'b0;
    core_underrun = 1'b0;
    core_fifo_count = 4'h0;
    dma_ack = 1'b0;
    trigger_timer = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // one sample word; called right after a clock edge
  task automatic give_sample(input logic [15:0] v);
    core_sample_valid <= 1'b1;
    core_sample <= v;
    @(posedge clk);
    core_sample_valid <= 1'b0;
    // stale data inverted so nothing leans on a held value
    core_sample <= ~v;
  endtask

  // one-hot by sel: overrun, underrun, cal end, dma acknowledge, timer tick
  task automatic pulse(input int sel, input int len);
    {trigger_timer, dma_ack, core_cal_done, core_underrun, core_overrun} <= 5'h01 << sel;
    repeat (len) @(posedge clk);
    {trigger_timer, dma_ack, core_cal_done, core_underrun, core_overrun} <= 5'h00;
  endtask

  // words waiting in the core fifo
  task automatic set_count(input logic [3:0] v);
    core_fifo_count <= v;
  endtask
endmodule

/* File: sim/adc_irq_cal_dma_control_tb.sv */
// self-checking bench for the converter control block
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
    end \
  end

module adc_irq_cal_dma_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        core_sample_valid;
  logic [15:0] core_sample;
  logic        core_cal_done;
  logic        core_overrun;
  logic        core_underrun;
  logic [3:0]  core_fifo_count;
  logic        core_start;
  logic        core_cal_mode;
  logic        core_system_gain;
  logic [3:0]  analog_input_select;
  logic        input_polarity_mode;
  logic [1:0]  oversampling_setting;
  logic        dma_req;
  logic        dma_ack;
  logic        trigger_timer;
  logic [31:0] rd;
  int          error_cnt;
  int          comparisons;
  int          starts;

  aicd_top #(.FIFO_DEPTH_W(4)) dut_u (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .core_sample_valid(core_sample_valid),
    .core_sample(core_sample), .core_cal_done(core_cal_done), .core_overrun(core_overrun),
    .core_underrun(core_underrun), .core_fifo_count(core_fifo_count), .core_start(core_start),
    .core_cal_mode(core_cal_mode), .core_system_gain(core_system_gain),
    .analog_input_select(analog_input_select), .input_polarity_mode(input_polarity_mode),
    .oversampling_setting(oversampling_setting), .dma_req(dma_req), .dma_ack(dma_ack),
    .trigger_timer(trigger_timer));

  aicd_partner mdl_u (
    .clk(clk), .core_sample_valid(core_sample_valid), .core_sample(core_sample),
    .core_cal_done(core_cal_done), .core_overrun(core_overrun), .core_underrun(core_underrun),
    .core_fifo_count(core_fifo_count), .dma_ack(dma_ack), .trigger_timer(trigger_timer));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (core_start === 1'b1) starts++;
  end

  ////////////////////////////////////////////////////////////////
  // one avalon access; a spare edge keeps back-to-back drives apart
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    // only the watchdog ends a hung wait
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(aicd_pkg::OFS_MASK, 32'h0000_007F);
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0000);
    rd_chk(aicd_pkg::OFS_CLEAR, 32'h0000_0000);
    rd_chk(8'h3C, 32'h0000_0000);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_irq;
    mdl_u.pulse(0, 1);
    mdl_u.pulse(1, 1);
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0060);
    rd_chk(aicd_pkg::OFS_MASKED_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    bus(1'b1, aicd_pkg::OFS_MASK, 32'h0000_001F);
    rd_chk(aicd_pkg::OFS_MASK, 32'h0000_001F);
    rd_chk(aicd_pkg::OFS_MASKED_STAT, 32'h0000_0060);
    `CHK(irq, 1'b1)
    bus(1'b1, aicd_pkg::OFS_CLEAR, 32'h0000_0000);
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0060);
    bus(1'b1, aicd_pkg::OFS_CLEAR, 32'h0000_0020);
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0040);
    bus(1'b1, aicd_pkg::OFS_MASK, 32'h0000_005F);
    rd_chk(aicd_pkg::OFS_MASKED_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    bus(1'b1, aicd_pkg::OFS_CLEAR, 32'h0000_0040);
    // event lands on the very edge the clear takes effect
    fork
      bus(1'b1, aicd_pkg::OFS_CLEAR, 32'h0000_0020);
      begin
        @(posedge clk);
        mdl_u.pulse(0, 1);
      end
    join
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0020);
    bus(1'b1, aicd_pkg::OFS_CLEAR, 32'h0000_0020);
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0000);
  endtask

  task automatic t_result;
    mdl_u.give_sample(16'h0FFF);
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0001);
    rd_chk(aicd_pkg::OFS_RESULT, 32'h0000_FFFF);
    mdl_u.give_sample(16'h0400);
    rd_chk(aicd_pkg::OFS_RESULT, 32'h0000_0400);
    bus(1'b1, aicd_pkg::OFS_CLEAR, 32'h0000_007F, 4'h2);
    rd_chk(aicd_pkg::OFS_RAW_STAT, 32'h0000_0001);
    bus(1'b1, aicd_pkg::OFS_CLEAR, 32'h0000_007F);
  endtask

  task automatic t_cal;
    bus(1'b1, aicd_pkg::OFS_GENERAL, 32'h0000_0001);
    bus(1'b1, aicd_pkg::OFS_CMD, 32'h0000_0000);
    bus(1'b1, aicd_pkg::OFS_GENERAL, 32'h0000_0003);
    bus(1'b1, aicd_pkg::OFS_CMD, 32'h0000_0001);
    `CHK(core_cal_mode, 1'b1)
    mdl_u.give_sample(16'h0012);
    bus(1'b1, aicd_pkg::OFS_ANA, 32'h0000_0009);
    mdl_u.give_sample(16'h7FF0);
    rd_chk(aicd_pkg::OFS_OFFSET_CAL, 32'h0000_0012);
    rd_chk(aicd_pkg::OFS_GAIN_CAL, 32'h0000_000F);
    bus(1'b1, aicd_pkg::OFS_CONFIG, 32'h0000_0008);
    `CHK(core_system_gain, 1'b1)
    mdl_u.give_sample(16'h7AD0);
    rd_chk(aicd_pkg::OFS_GAIN_CAL, 32'h0000_0011);
    mdl_u.pulse(2, 1);
    rd_chk(aicd_pkg::OFS_GENERAL, 32'h0000_0001);
    rd_chk(aicd_pkg::OFS_OFFSET_CAL, 32'h0000_0012);
    bus(1'b1, aicd_pkg::OFS_CMD, 32'h0000_0000);
    bus(1'b1, aicd_pkg::OFS_CONFIG, 32'h0000_0001);
    rd_chk(aicd_pkg::OFS_OFFSET_CAL, 32'h0000_0000);
    rd_chk(aicd_pkg::OFS_GAIN_CAL, 32'h0000_0000);
    bus(1'b1, aicd_pkg::OFS_CONFIG, 32'h0000_0002);
    bus(1'b1, aicd_pkg::OFS_OFFSET_CAL, 32'h0010_0000);
    rd_chk(aicd_pkg::OFS_OFFSET_CAL, 32'h0010_0000);
    mdl_u.give_sample(16'h0100);
    rd_chk(aicd_pkg::OFS_RESULT, 32'h0000_00F0);
  endtask

  task automatic t_dma;
    mdl_u.set_count(4'h3);
    bus(1'b1, aicd_pkg::OFS_DMA, 32'h0000_0401);
    `CHK(dma_req, 1'b0)
    mdl_u.set_count(4'h4);
    repeat (3) @(posedge clk);
    `CHK(dma_req, 1'b1)
    mdl_u.set_count(4'h0);
    rd_chk(aicd_pkg::OFS_RESULT, 32'h0000_00F0);
    `CHK(dma_req, 1'b1)
    mdl_u.pulse(3, 1);
    repeat (2) @(posedge clk);
    `CHK(dma_req, 1'b0)
  endtask

  task automatic t_trigger;
    bus(1'b1, aicd_pkg::OFS_CONFIG, 32'h0000_0000);
    starts = 0;
    mdl_u.pulse(4, 3);
    repeat (6) @(posedge clk);
    `CHK(starts, 0)
    bus(1'b1, aicd_pkg::OFS_CONFIG, 32'h0000_0004);
    starts = 0;
    mdl_u.pulse(4, 3);
    repeat (6) @(posedge clk);
    `CHK(starts, 1)
  endtask

  task automatic t_battery;
    bus(1'b1, aicd_pkg::OFS_ANA, 32'h0000_0008);
    `CHK(analog_input_select, aicd_pkg::AMUX_BATTERY)
    `CHK(input_polarity_mode, 1'b0)
    bus(1'b1, aicd_pkg::OFS_ANA, 32'h0000_0001);
    `CHK(analog_input_select, 4'h1)
    bus(1'b1, aicd_pkg::OFS_ANA, 32'h0000_0300, 4'h2);
    `CHK(oversampling_setting, 2'b11)
    `CHK(analog_input_select, 4'h1)
    mdl_u.give_sample(16'h0800);
    rd_chk(aicd_pkg::OFS_RESULT, 32'h0000_0800);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    error_cnt = 0;
    comparisons = 0;
    starts = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_irq();
    t_result();
    t_cal();
    t_dma();
    t_trigger();
    t_battery();
    tally_and_finish();
  end
endmodule
